//--- hdl/ops_pkg.sv
// Package for the output power sequencer: command codes, reset values, timing constants.
// Assumes a command port driven by a bus front end that decodes page and command code.
package ops_pkg;
    localparam int PAGES = 2;
    localparam logic [7:0] CMD_PG_THRESHOLD = 8'h5e;
    localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
    localparam logic [7:0] CMD_TURN_ON_RISE_TIME = 8'h61;
    localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
    localparam logic [7:0] CMD_TURN_OFF_FALL_TIME = 8'h65;
    localparam logic [15:0] TIME_RESET = 16'hca80;
    // Linear-11 field positions
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MANT_MSB = 10;
    // Timebase: one tick per microsecond-ish unit of 1/1024 ms
    localparam int CLK_HZ = 50_000_000;
    localparam int TICKS_PER_MS = 1024;
    localparam int TICK_CYCLES = CLK_HZ / (1000 * TICKS_PER_MS);
    // Fall time below 0.5 ms means immediate tri-state
    localparam logic [31:0] FALL_MIN_TICKS = 32'h0000_0200;
    localparam int CNT_W = 32;

    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_ON_WAIT = 5'b00010,
        ST_RISE = 5'b00100,
        ST_ON = 5'b01000,
        ST_OFF_WAIT = 5'b10000
    } ops_state_type;

    typedef struct packed {
        logic [15:0] pg_threshold;
        logic [15:0] turn_on_delay;
        logic [15:0] turn_on_rise_time;
        logic [15:0] turn_off_delay;
        logic [15:0] turn_off_fall_time;
    } ops_cfg_type;

    // Linear-11 ms value to ticks of 1/1024 ms; negative results clamp to zero
    function automatic logic [CNT_W-1:0] lin11_ticks(input logic [15:0] v);
        logic signed [5:0] sh;
        logic signed [10:0] m;
        logic [CNT_W-1:0] r;
        sh = 6'($signed(v[EXP_MSB:EXP_LSB])) + 6'sd10;
        m = $signed(v[MANT_MSB:0]);
        r = '0;
        if (m > 0) begin
            if (sh >= 0) begin
                r = CNT_W'(32'(m) << sh);
            end else begin
                r = CNT_W'(32'(m) >> (-sh));
            end
        end
        return r;
    endfunction : lin11_ticks
endpackage : ops_pkg

//--- hdl/ops_channel.sv
// One output's sequencing machine: delays, ramp, power-good hysteresis.
// Assumes a shared tick strobe and voltages already in the same unsigned scale.
`timescale 1ns/1ps
module ops_channel (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic enable,
    input wire logic multi_phase,
    input wire logic [15:0] ramp_gain_ticks,
    input wire ops_pkg::ops_cfg_type cfg,
    input wire logic [15:0] vout_meas,
    input wire logic [15:0] uv_fault_limit,
    output logic pwm_en_reg,
    output logic ramp_dir_up_reg,
    output logic ramping_reg,
    output logic power_good_reg,
    output ops_pkg::ops_state_type state_reg
);
    logic [ops_pkg::CNT_W-1:0] cnt_reg;
    logic [ops_pkg::CNT_W-1:0] fall_ticks;
    logic done;

    assign fall_ticks = ops_pkg::lin11_ticks(cfg.turn_off_fall_time);
    assign done = (cnt_reg == '0);

    // Sequencing per page, counting in shared timebase ticks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ops_pkg::ST_OFF;
            cnt_reg <= '0;
            pwm_en_reg <= 1'b0;
            ramping_reg <= 1'b0;
            ramp_dir_up_reg <= 1'b0;
        end else if (ce) begin
            case (state_reg)
                ops_pkg::ST_OFF: begin
                    if (enable) begin
                        state_reg <= ops_pkg::ST_ON_WAIT;
                        cnt_reg <= ops_pkg::lin11_ticks(cfg.turn_on_delay);
                    end
                end
                ops_pkg::ST_ON_WAIT: begin
                    if (!enable) begin
                        state_reg <= ops_pkg::ST_OFF;
                    end else if (done) begin
                        state_reg <= ops_pkg::ST_RISE;
                        pwm_en_reg <= 1'b1;
                        ramping_reg <= 1'b1;
                        ramp_dir_up_reg <= 1'b1;
                        if (multi_phase) begin
                            cnt_reg <= 32'(ramp_gain_ticks);
                        end else begin
                            cnt_reg <= ops_pkg::lin11_ticks(cfg.turn_on_rise_time);
                        end
                    end else if (tick) begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
                ops_pkg::ST_RISE, ops_pkg::ST_ON: begin
                    if (!enable) begin
                        state_reg <= ops_pkg::ST_OFF_WAIT;
                        ramping_reg <= 1'b0;
                        cnt_reg <= ops_pkg::lin11_ticks(cfg.turn_off_delay);
                    end else if (state_reg == ops_pkg::ST_RISE && done) begin
                        state_reg <= ops_pkg::ST_ON;
                        ramping_reg <= 1'b0;
                    end else if (tick && !done) begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
                ops_pkg::ST_OFF_WAIT: begin
                    if (done) begin
                        if (multi_phase || fall_ticks < ops_pkg::FALL_MIN_TICKS) begin
                            state_reg <= ops_pkg::ST_OFF;
                            pwm_en_reg <= 1'b0;
                            ramping_reg <= 1'b0;
                        end else if (!ramping_reg) begin
                            ramping_reg <= 1'b1;
                            ramp_dir_up_reg <= 1'b0;
                            cnt_reg <= fall_ticks;
                        end else begin
                            state_reg <= ops_pkg::ST_OFF;
                            pwm_en_reg <= 1'b0;
                            ramping_reg <= 1'b0;
                        end
                    end else if (tick) begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
                default: state_reg <= ops_pkg::ST_OFF;
            endcase
        end
    end

    // Power-good with hysteresis: on above threshold, off below UV limit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_good_reg <= 1'b0;
        end else if (ce) begin
            if (vout_meas > cfg.pg_threshold) begin
                power_good_reg <= 1'b1;
            end else if (vout_meas < uv_fault_limit) begin
                power_good_reg <= 1'b0;
            end
        end
    end

    a_pg_rise: assert property (@(posedge mclk) disable iff (rst)
        ce && vout_meas > cfg.pg_threshold |=> power_good_reg)
        else $error("power good not raised");
    a_pg_fall: assert property (@(posedge mclk) disable iff (rst)
        ce && vout_meas < uv_fault_limit && vout_meas <= cfg.pg_threshold
        |=> !power_good_reg)
        else $error("power good not dropped");
    a_pg_hold: assert property (@(posedge mclk) disable iff (rst)
        ce && vout_meas >= uv_fault_limit && power_good_reg |=> power_good_reg)
        else $error("power good lost inside hysteresis");
    a_on_delay: assert property (@(posedge mclk) disable iff (rst)
        state_reg == ops_pkg::ST_ON_WAIT && !done |=> !ramping_reg)
        else $error("ramp started before delay");
    a_rise_dir: assert property (@(posedge mclk) disable iff (rst)
        ce && state_reg == ops_pkg::ST_ON_WAIT && enable && done
        |=> ramping_reg && ramp_dir_up_reg && pwm_en_reg)
        else $error("rise did not start");
    a_mp_load: assert property (@(posedge mclk) disable iff (rst)
        ce && state_reg == ops_pkg::ST_ON_WAIT && enable && done && multi_phase
        |=> cnt_reg == 32'($past(ramp_gain_ticks)))
        else $error("multi phase ramp not from gain");
    a_off_delay: assert property (@(posedge mclk) disable iff (rst)
        ce && state_reg == ops_pkg::ST_ON && !enable
        |=> state_reg == ops_pkg::ST_OFF_WAIT && pwm_en_reg)
        else $error("turn off delay skipped");
    a_tristate: assert property (@(posedge mclk) disable iff (rst)
        ce && state_reg == ops_pkg::ST_OFF_WAIT && done
        && (multi_phase || fall_ticks < ops_pkg::FALL_MIN_TICKS)
        |=> !pwm_en_reg && state_reg == ops_pkg::ST_OFF)
        else $error("no immediate tri-state");
    a_fall_ramp: assert property (@(posedge mclk) disable iff (rst)
        ce && state_reg == ops_pkg::ST_OFF_WAIT && done && !ramping_reg && !multi_phase
        && fall_ticks >= ops_pkg::FALL_MIN_TICKS |=> ramping_reg && !ramp_dir_up_reg)
        else $error("fall ramp missing");
endmodule : ops_channel

//--- hdl/ops_sequencer.sv
// Top of the output power sequencer: paged command registers and per-page channels.
// Assumes a bus front end presenting decoded page, command code and word strobes.
`timescale 1ns/1ps
// How it works
// - Power-good rises once the measured output exceeds the page's threshold.
// - Power-good falls only when the output drops below the undervoltage fault limit.
// - The threshold is a 16-bit paged unsigned word defaulting to 0.9 of the strap voltage.
// - After enable the output waits the turn-on delay before rising.
// - Both delays take 0 to 5 s (the code stores any written word with no range check) and reset to code 0xca80, i.e. 5 ms.
// - All four times are linear-11: mantissa times two to the exponent, in ms.
// - Each time setting is a 16-bit per-page read-write word.
// - Single or dual channel ramps up over the rise time after the delay.
// - Multi-phase takes the ramp from the ramp gain setting instead.
// - After disable the output waits the turn-off delay before falling.
// - Single or dual channel ramps down over the fall time after the delay.
// - A fall time under 0.5 ms tri-states the drivers at once after the delay.
// - Multi-phase always tri-states at once after the delay.
module ops_sequencer #(
    parameter int PAGES = ops_pkg::PAGES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [0:0] cmd_page,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] strap_vout [PAGES],
    input wire logic [PAGES-1:0] enable_pin,
    input wire logic multi_phase_pin,
    input wire logic [15:0] ramp_gain_ticks,
    input wire logic [15:0] vout_meas [PAGES],
    input wire logic [15:0] uv_fault_limit [PAGES],
    output logic [15:0] cmd_rdata_reg,
    output logic cmd_ack_reg,
    output logic cmd_nak_reg,
    output logic [PAGES-1:0] pwm_en_reg,
    output logic [PAGES-1:0] ramp_up_reg,
    output logic [PAGES-1:0] ramping_reg,
    output logic [PAGES-1:0] power_good_reg
);
    ops_pkg::ops_cfg_type cfg_reg [PAGES];
    logic strap_done_reg;
    logic [PAGES-1:0] en_s1_reg;
    logic [PAGES-1:0] en_s2_reg;
    logic mp_s1_reg;
    logic mp_s2_reg;
    logic [7:0] tick_cnt_reg;
    logic tick_reg;

    // 0.9 approximated as 461/512; strap read once after reset release
    function automatic logic [15:0] pg_default(input logic [15:0] v);
        logic [24:0] p;
        p = 25'(v) * 25'd461;
        return p[24:9];
    endfunction : pg_default

    function automatic logic known_cmd(input logic [7:0] c);
        return c == ops_pkg::CMD_PG_THRESHOLD || c == ops_pkg::CMD_TURN_ON_DELAY
            || c == ops_pkg::CMD_TURN_ON_RISE_TIME || c == ops_pkg::CMD_TURN_OFF_DELAY
            || c == ops_pkg::CMD_TURN_OFF_FALL_TIME;
    endfunction : known_cmd

    // Pin inputs are asynchronous to mclk
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_s1_reg <= '0;
            en_s2_reg <= '0;
            mp_s1_reg <= 1'b0;
            mp_s2_reg <= 1'b0;
        end else if (ce) begin
            en_s1_reg <= enable_pin;
            en_s2_reg <= en_s1_reg;
            mp_s1_reg <= multi_phase_pin;
            mp_s2_reg <= mp_s1_reg;
        end
    end

    // Shared timebase, one tick per 1/1024 ms
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            tick_reg <= (tick_cnt_reg == 8'(ops_pkg::TICK_CYCLES - 1));
            if (tick_cnt_reg == 8'(ops_pkg::TICK_CYCLES - 1)) begin
                tick_cnt_reg <= '0;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 8'h01;
            end
        end
    end

    // Paged configuration words
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strap_done_reg <= 1'b0;
            for (int p = 0; p < PAGES; p++) begin
                cfg_reg[p].pg_threshold <= '0;
                cfg_reg[p].turn_on_delay <= ops_pkg::TIME_RESET;
                cfg_reg[p].turn_on_rise_time <= ops_pkg::TIME_RESET;
                cfg_reg[p].turn_off_delay <= ops_pkg::TIME_RESET;
                cfg_reg[p].turn_off_fall_time <= ops_pkg::TIME_RESET;
            end
        end else if (ce) begin
            if (!strap_done_reg) begin
                strap_done_reg <= 1'b1;
                for (int p = 0; p < PAGES; p++) begin
                    cfg_reg[p].pg_threshold <= pg_default(strap_vout[p]);
                end
            end else if (cmd_wr) begin
                case (cmd_code)
                    ops_pkg::CMD_PG_THRESHOLD: cfg_reg[cmd_page].pg_threshold <= cmd_wdata;
                    ops_pkg::CMD_TURN_ON_DELAY: cfg_reg[cmd_page].turn_on_delay <= cmd_wdata;
                    ops_pkg::CMD_TURN_ON_RISE_TIME: cfg_reg[cmd_page].turn_on_rise_time <= cmd_wdata;
                    ops_pkg::CMD_TURN_OFF_DELAY: cfg_reg[cmd_page].turn_off_delay <= cmd_wdata;
                    ops_pkg::CMD_TURN_OFF_FALL_TIME: cfg_reg[cmd_page].turn_off_fall_time <= cmd_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Read back and acknowledge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_rdata_reg <= '0;
            cmd_ack_reg <= 1'b0;
            cmd_nak_reg <= 1'b0;
        end else if (ce) begin
            cmd_ack_reg <= (cmd_wr || cmd_rd) && known_cmd(cmd_code);
            cmd_nak_reg <= (cmd_wr || cmd_rd) && !known_cmd(cmd_code);
            if (cmd_rd) begin
                case (cmd_code)
                    ops_pkg::CMD_PG_THRESHOLD: cmd_rdata_reg <= cfg_reg[cmd_page].pg_threshold;
                    ops_pkg::CMD_TURN_ON_DELAY: cmd_rdata_reg <= cfg_reg[cmd_page].turn_on_delay;
                    ops_pkg::CMD_TURN_ON_RISE_TIME: cmd_rdata_reg <= cfg_reg[cmd_page].turn_on_rise_time;
                    ops_pkg::CMD_TURN_OFF_DELAY: cmd_rdata_reg <= cfg_reg[cmd_page].turn_off_delay;
                    ops_pkg::CMD_TURN_OFF_FALL_TIME: cmd_rdata_reg <= cfg_reg[cmd_page].turn_off_fall_time;
                    default: cmd_rdata_reg <= '0;
                endcase
            end
        end
    end

    a_time_reset: assert property (@(posedge mclk) disable iff (rst)
        !strap_done_reg |-> cfg_reg[0].turn_on_delay == ops_pkg::TIME_RESET
        && cfg_reg[0].turn_off_delay == ops_pkg::TIME_RESET)
        else $error("delay reset code wrong");
    a_rd_back: assert property (@(posedge mclk) disable iff (rst)
        ce && strap_done_reg && cmd_wr && cmd_code == ops_pkg::CMD_TURN_ON_DELAY
        ##1 ce && cmd_rd && !cmd_wr && cmd_code == ops_pkg::CMD_TURN_ON_DELAY
        && cmd_page == $past(cmd_page) |=> cmd_rdata_reg == $past(cmd_wdata, 2))
        else $error("read back mismatch");

    // Each page owns an independent machine
    for (genvar g = 0; g < PAGES; g++) begin : g_page
        ops_channel u_ch (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .tick(tick_reg),
            .enable(en_s2_reg[g] && strap_done_reg),
            .multi_phase(mp_s2_reg),
            .ramp_gain_ticks(ramp_gain_ticks),
            .cfg(cfg_reg[g]),
            .vout_meas(vout_meas[g]),
            .uv_fault_limit(uv_fault_limit[g]),
            .pwm_en_reg(pwm_en_reg[g]),
            .ramp_dir_up_reg(ramp_up_reg[g]),
            .ramping_reg(ramping_reg[g]),
            .power_good_reg(power_good_reg[g]),
            .state_reg()
        );
    end
endmodule : ops_sequencer

//--- tb/ops_stage_model.sv
// Behavioural power stage and load: output level follows the sequencer's drive outputs.
// Assumes one output per page and a load sag on each output set by the bench.
`timescale 1ns/1ps
module ops_stage_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] pwm_en,
    input wire logic [1:0] ramp_up,
    input wire logic [1:0] ramping,
    input wire logic [15:0] target [2],
    input wire logic [15:0] sag [2],
    output logic [15:0] vout [2]
);
    logic [15:0] level_reg [2];
    // Tri-stated stage discharges fast into the load, never gracefully
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_reg <= '{16'h0000, 16'h0000};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!pwm_en[i]) begin
                    level_reg[i] <= (level_reg[i] > 16'h0040) ? level_reg[i] - 16'h0040 : 16'h0000;
                end else if (ramping[i] && ramp_up[i]) begin
                    level_reg[i] <= (level_reg[i] < target[i]) ? level_reg[i] + 16'h0001 : target[i];
                end else if (ramping[i]) begin
                    level_reg[i] <= (level_reg[i] != 16'h0000) ? level_reg[i] - 16'h0001 : 16'h0000;
                end else if (ramp_up[i]) begin
                    level_reg[i] <= target[i];
                end
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            vout[i] = (level_reg[i] > sag[i]) ? level_reg[i] - sag[i] : 16'h0000;
        end
    end
endmodule : ops_stage_model

//--- tb/tb_top.sv
// Self-checking bench for the output power sequencer: registers, sequencing, power-good.
// Assumes the stage model closes the loop from drive outputs to measured voltage.
`timescale 1ns/1ps
module tb_top;
    localparam int T = ops_pkg::TICK_CYCLES;
    localparam int G = 6;
    logic mclk, rst, ce, cmd_wr, cmd_rd, multi_phase_pin, cmd_ack_reg, cmd_nak_reg, ack, nak;
    logic [0:0] cmd_page;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, ramp_gain_ticks, cmd_rdata_reg, rd;
    logic [15:0] strap_vout [2];
    logic [15:0] vout_meas [2];
    logic [15:0] uv_fault_limit [2];
    logic [15:0] sag [2];
    logic [15:0] shadow [2][5];
    logic [7:0] codes [5];
    logic [1:0] enable_pin, pwm_en_reg, ramp_up_reg, ramping_reg, power_good_reg;
    logic [31:0] seed;
    int miscompares, n_checks, cyc, n;
    ops_sequencer #(.PAGES(2)) u_dut (.mclk(mclk), .rst(rst), .ce(ce), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .strap_vout(strap_vout), .enable_pin(enable_pin), .multi_phase_pin(multi_phase_pin),
        .ramp_gain_ticks(ramp_gain_ticks), .vout_meas(vout_meas),
        .uv_fault_limit(uv_fault_limit), .cmd_rdata_reg(cmd_rdata_reg),
        .cmd_ack_reg(cmd_ack_reg), .cmd_nak_reg(cmd_nak_reg), .pwm_en_reg(pwm_en_reg),
        .ramp_up_reg(ramp_up_reg), .ramping_reg(ramping_reg), .power_good_reg(power_good_reg));
    ops_stage_model u_stage (.mclk(mclk), .rst(rst), .pwm_en(pwm_en_reg), .ramp_up(ramp_up_reg),
        .ramping(ramping_reg), .target(strap_vout), .sag(sag), .vout(vout_meas));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    // Default threshold as 461/512 of the strap, truncated
    function automatic logic [15:0] thr_def(input logic [15:0] s);
        return 16'((32'(s) * 461) >> 9);
    endfunction : thr_def
    function automatic int ticks(input logic [15:0] v);
        int sh;
        int y;
        sh = int'($signed(v[15:11])) + 10;
        y = int'($signed(v[10:0]));
        if (y <= 0) return 0;
        return (sh >= 0) ? (y << sh) : (y >>> -sh);
    endfunction : ticks
    function automatic logic pick(input int p, input int sel);
        return (sel == 0) ? pwm_en_reg[p] : (sel == 1) ? ramping_reg[p] : power_good_reg[p];
    endfunction : pick
    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %b", $time, what, got);
        end
    endtask : chk1
    task automatic chk_rng(input int v, input int lo, input int hi, input string what);
        n_checks++;
        if (v < lo || v > hi) begin
            miscompares++;
            $display("[FAIL] %0t %s took %0d cycles, want %0d..%0d", $time, what, v, lo, hi);
        end
    endtask : chk_rng
    // Strobes stay up between calls so back-to-back commands never toggle in one step
    task automatic xfer(input logic wr, input int p, input logic [7:0] code, input logic [15:0] wd);
        cmd_wr = wr;
        cmd_rd = !wr;
        cmd_page = 1'(p);
        cmd_code = code;
        cmd_wdata = wd;
        @(negedge mclk);
        rd = cmd_rdata_reg;
        ack = cmd_ack_reg;
        nak = cmd_nak_reg;
    endtask : xfer
    task automatic idle();
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        @(negedge mclk);
    endtask : idle
    task automatic measure(input int p, input int sel, input logic v);
        n = 0;
        while (pick(p, sel) !== v && n < 40000) begin
            @(negedge mclk);
            n++;
        end
    endtask : measure
    task automatic hyst();
        sag[0] = 16'h01a0 + 16'(rnd() % 32'h0000_0250);
        repeat (20) @(negedge mclk);
        chk1(power_good_reg[0], 1'b1, "pg held above uv limit");
        sag[0] = 16'h0500;
        measure(0, 2, 1'b0);
        chk_rng(n, 0, 10, "pg drop below uv limit");
        sag[0] = 16'h01a0 + 16'(rnd() % 32'h0000_0250);
        repeat (20) @(negedge mclk);
        chk1(power_good_reg[0], 1'b0, "pg low under threshold");
        sag[0] = 16'h0000;
        measure(0, 2, 1'b1);
        chk_rng(n, 0, 10, "pg rise above threshold");
        $display("test power-good hysteresis done");
    endtask : hyst
    task automatic seq_run(input int p, input logic mp, input logic [15:0] fall);
        int d_on;
        int d_off;
        logic [15:0] rise;
        d_on = 2 + int'(rnd() % 12);
        d_off = 2 + int'(rnd() % 12);
        rise = 16'hb200 | 16'(rnd() % 16);
        multi_phase_pin = mp;
        xfer(1'b1, p, codes[0], thr_def(strap_vout[p]));
        xfer(1'b1, p, codes[1], 16'hb000 | 16'(d_on));
        xfer(1'b1, p, codes[2], rise);
        xfer(1'b1, p, codes[3], 16'hb000 | 16'(d_off));
        xfer(1'b1, p, codes[4], fall);
        idle();
        chk1(power_good_reg[p], 1'b0, "pg before start");
        enable_pin[p] = 1'b1;
        measure(p, 0, 1'b1);
        chk_rng(n, (d_on - 1) * T, (d_on + 1) * T + 8, "turn-on delay");
        chk1(ramp_up_reg[p], 1'b1, "ramp direction up");
        measure(p, 1, 1'b0);
        if (mp)
            chk_rng(n, (G - 1) * T, (G + 1) * T + 4, "multi-phase rise");
        else
            chk_rng(n, (ticks(rise) - 1) * T, (ticks(rise) + 1) * T + 4, "rise time");
        measure(p, 2, 1'b1);
        chk_rng(n, 0, 10, "pg at target");
        if (p == 0 && !mp)
            hyst();
        enable_pin[p] = 1'b0;
        if (mp || ticks(fall) < 512) begin
            measure(p, 0, 1'b0);
            chk_rng(n, (d_off - 1) * T, (d_off + 1) * T + 8, "tri-state after delay");
            if (mp)
                chk1(ramping_reg[p], 1'b0, "no fall ramp multi-phase");
            else
                chk1(ramping_reg[p], 1'b0, "no fall ramp short fall");
        end else begin
            measure(p, 1, 1'b1);
            chk_rng(n, (d_off - 1) * T, (d_off + 1) * T + 8, "turn-off delay");
            chk1(ramp_up_reg[p], 1'b0, "ramp direction down");
            measure(p, 0, 1'b0);
            chk_rng(n, (ticks(fall) - 1) * T, (ticks(fall) + 1) * T + 4, "fall time");
        end
        repeat (200) @(negedge mclk);
        chk1(power_good_reg[p], 1'b0, "pg after discharge");
        $display("test sequence page %0d multi %0d done", p, mp);
    endtask : seq_run
    // Runaway guard well above the longest expected ramps
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        codes = '{ops_pkg::CMD_PG_THRESHOLD, ops_pkg::CMD_TURN_ON_DELAY, ops_pkg::CMD_TURN_ON_RISE_TIME,
                  ops_pkg::CMD_TURN_OFF_DELAY, ops_pkg::CMD_TURN_OFF_FALL_TIME};
        seed = 32'hecb9_70b3;
        miscompares = 0;
        n_checks = 0;
        cyc = 0;
        {rst, ce, cmd_wr, cmd_rd, multi_phase_pin, enable_pin} = {6'b11_0000, 1'b0};
        {cmd_page, cmd_code, cmd_wdata, ramp_gain_ticks} = {1'b0, 8'h00, 16'h0000, 16'(G)};
        strap_vout[0] = 16'h1000;
        strap_vout[1] = 16'h0800 + 16'(rnd() % 32'h0000_0800);
        sag = '{16'h0000, 16'h0000};
        for (int p = 0; p < 2; p++) uv_fault_limit[p] = strap_vout[p] - (strap_vout[p] >> 2);
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                xfer(1'b0, p, codes[i], 16'h0000);
                if (i == 0)
                    chk(rd, thr_def(strap_vout[p]), "threshold default");
                else
                    chk(rd, ops_pkg::TIME_RESET, "time default");
            end
        end
        for (int k = 0; k < 4; k++) begin
            // Codes 62, 63, 66, 67: neighbours of the real ones, all unknown
            xfer(1'b1, k % 2, 8'h62 + 8'(k) + ((k > 1) ? 8'h02 : 8'h00), 16'(rnd()));
            chk1(nak, 1'b1, "unknown write nak");
            xfer(1'b0, k % 2, 8'h62 + 8'(k) + ((k > 1) ? 8'h02 : 8'h00), 16'h0000);
            chk(rd, 16'h0000, "unknown read data");
        end
        $display("test reset values and unknown codes done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                shadow[p][i] = 16'(rnd());
                xfer(1'b1, p, codes[i], shadow[p][i]);
                chk1(ack, 1'b1, "write ack");
                xfer(1'b0, p, codes[i], 16'h0000);
                chk(rd, shadow[p][i], "read after write");
            end
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                xfer(1'b0, p, codes[i], 16'h0000);
                chk(rd, shadow[p][i], "page readback");
            end
        end
        // Clock enable low must freeze the register file
        ce = 1'b0;
        xfer(1'b1, 0, codes[1], ~shadow[0][1]);
        ce = 1'b1;
        xfer(1'b0, 0, codes[1], 16'h0000);
        chk(rd, shadow[0][1], "write while frozen");
        idle();
        $display("test register access done");
        seq_run(0, 1'b0, 16'hb1ff);
        seq_run(1, 1'b0, 16'hf801);
        seq_run(0, 1'b1, 16'hf801);
        complete_run();
    end
endmodule : tb_top
